/* File: rtl/udss_string_store.sv */
/*
  String descriptor store: serial, maker and product byte arrays with a
  register port (EEPROM or SMBus loader) and a descriptor read port that
  streams the content of a requested string index.
  Assumes loader and descriptor engine run on mclk; the length settings and
  the custom serial select come from configuration registers elsewhere.
*/
// Contract
// - Serial array bytes are the content of string index 1.
// - Serial array resets to a per-device default, not a fixed design value; the code resets it to the fixed SERIAL_DEFAULT, 8'h00.
// - Serial array is writable only while custom serial select is 1.
// - Product string index 2 is returned only when its length is above zero.
// - Product bytes returned equal product length, from array start; the code stops at 64 bytes when the length is larger.
`timescale 1ns/10ps
module udss_string_store (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       customSerialSelect,
  input  wire logic [6:0] makerStringLength,
  input  wire logic [6:0] productStringLength,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            regAck,
  input  wire logic       descReq,
  input  wire logic [1:0] descIndex,
  output logic            descValid,
  output logic      [7:0] descByte,
  output logic            descLast,
  output logic            descAbsent
);
  import udss_pkg::*;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic inSerial;
  logic inMaker;
  logic inProduct;
  assign inSerial  = (regAddr >= SERIAL_BASE)  && (regAddr <= SERIAL_LAST);
  assign inMaker   = (regAddr >= MAKER_BASE)   && (regAddr <= MAKER_LAST);
  assign inProduct = (regAddr >= PRODUCT_BASE) && (regAddr <= PRODUCT_LAST);

  logic [4:0] serialWrIdx;
  logic [5:0] makerWrIdx;
  logic [5:0] productWrIdx;
  assign serialWrIdx  = 5'(regAddr - SERIAL_BASE);
  assign makerWrIdx   = 6'(regAddr - MAKER_BASE);
  assign productWrIdx = 6'(regAddr - PRODUCT_BASE);

  typedef struct packed {
    udss_state_t state;
    logic [1:0]  index;
    logic [6:0]  count;
    logic [6:0]  length;
    logic        valid;
    logic [7:0]  data;
    logic        last;
    logic        absent;
    logic [7:0]  rdData;
    logic        ack;
  } udss_ctl_t;

  udss_ctl_t ctl_q;
  udss_ctl_t ctl_d;

  // ----------------------------------------------------------------
  // Arrays
  // ----------------------------------------------------------------
  logic       serialWr;
  logic [4:0] serialRdIdx;
  logic [5:0] stringRdIdx;
  logic [7:0] serialRd;
  logic [7:0] makerRd;
  logic [7:0] productRd;
  logic       descActive;

  // Descriptor streaming owns the read index; register reads use it when idle
  assign descActive  = (ctl_q.state == ST_SEND);
  assign serialRdIdx = descActive ? ctl_q.count[4:0] : serialWrIdx;
  assign stringRdIdx = descActive ? ctl_q.count[5:0]
                     : (inMaker ? makerWrIdx : productWrIdx);
  assign serialWr    = regWrite && inSerial && customSerialSelect;

  // Default stands in for the factory-programmed value
  udss_byte_array #(.DEPTH(SERIAL_DEPTH), .INIT(SERIAL_DEFAULT)) serialArr (
    .mclk    (mclk),
    .reset_n (reset_n),
    .wrEn    (serialWr),
    .wrIdx   (serialWrIdx),
    .wrData  (regWrData),
    .rdIdx   (serialRdIdx),
    .rdData  (serialRd)
  );

  udss_byte_array #(.DEPTH(STRING_DEPTH), .INIT(STRING_RESET)) makerArr (
    .mclk    (mclk),
    .reset_n (reset_n),
    .wrEn    (regWrite && inMaker),
    .wrIdx   (makerWrIdx),
    .wrData  (regWrData),
    .rdIdx   (stringRdIdx),
    .rdData  (makerRd)
  );

  udss_byte_array #(.DEPTH(STRING_DEPTH), .INIT(STRING_RESET)) productArr (
    .mclk    (mclk),
    .reset_n (reset_n),
    .wrEn    (regWrite && inProduct),
    .wrIdx   (productWrIdx),
    .wrData  (regWrData),
    .rdIdx   (stringRdIdx),
    .rdData  (productRd)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [6:0] reqLength;
  logic [7:0] curByte;

  always_comb begin
    ctl_d        = ctl_q;
    ctl_d.valid  = 1'b0;
    ctl_d.last   = 1'b0;
    ctl_d.absent = 1'b0;
    ctl_d.ack    = regRead || regWrite;
    reqLength    = 7'h00;
    curByte      = 8'h00;

    // Register read; unmapped addresses and active streaming read zero
    ctl_d.rdData = 8'h00;
    if (regRead && !descActive) begin
      if (inSerial) begin
        ctl_d.rdData = serialRd;
      end else if (inMaker) begin
        ctl_d.rdData = makerRd;
      end else if (inProduct) begin
        ctl_d.rdData = productRd;
      end
    end

    case (descIndex)
      IDX_SERIAL:  reqLength = 7'(SERIAL_DEPTH);
      IDX_MAKER:   reqLength = makerStringLength;
      IDX_PRODUCT: reqLength = productStringLength;
      default:     reqLength = 7'h00;
    endcase

    // Byte source follows the index latched when the request was taken
    case (ctl_q.index)
      IDX_SERIAL:  curByte = serialRd;
      IDX_MAKER:   curByte = makerRd;
      IDX_PRODUCT: curByte = productRd;
      default:     curByte = 8'h00;
    endcase

    case (ctl_q.state)
      ST_IDLE: begin
        if (descReq) begin
          // Zero length or index 0: answer absent, stream nothing
          if (reqLength == 7'h00) begin
            ctl_d.absent = 1'b1;
            ctl_d.state  = ST_DONE;
          end else begin
            ctl_d.index  = descIndex;
            ctl_d.length = reqLength;
            ctl_d.count  = 7'h00;
            ctl_d.state  = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        // Bytes from the array start, length clipped to array size
        ctl_d.valid = 1'b1;
        ctl_d.data  = curByte;
        ctl_d.count = ctl_q.count + 7'h01;
        if ((ctl_q.count + 7'h01 == ctl_q.length) ||
            (ctl_q.count == 7'(STRING_DEPTH - 1))) begin
          ctl_d.last  = 1'b1;
          ctl_d.state = ST_DONE;
        end
      end
      ST_DONE: begin
        // Wait for the request to drop so one request gets one reply
        if (!descReq) begin
          ctl_d.state = ST_IDLE;
        end
      end
      default: begin
        ctl_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= '{state: ST_IDLE, index: 2'h0, count: 7'h00, length: 7'h00,
                 valid: 1'b0, data: 8'h00, last: 1'b0, absent: 1'b0,
                 rdData: 8'h00, ack: 1'b0};
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdData  = ctl_q.rdData;
  assign regAck     = ctl_q.ack;
  assign descValid  = ctl_q.valid;
  assign descByte   = ctl_q.data;
  assign descLast   = ctl_q.last;
  assign descAbsent = ctl_q.absent;
endmodule

/* File: pkg/udss_pkg.sv */
/*
  Package of the string descriptor store: register offsets, array sizes and
  reset values imported by the store and its self-checking bench.
  Assumes a single 10 MHz clock domain.
*/
package udss_pkg;
  localparam logic [7:0] SERIAL_BASE    = 8'h30;
  localparam logic [7:0] SERIAL_LAST    = 8'h4F;
  localparam logic [7:0] MAKER_BASE     = 8'h50;
  localparam logic [7:0] MAKER_LAST     = 8'h8F;
  localparam logic [7:0] PRODUCT_BASE   = 8'h90;
  localparam logic [7:0] PRODUCT_LAST   = 8'hCF;
  localparam int         SERIAL_DEPTH   = 32;
  localparam int         STRING_DEPTH   = 64;
  localparam logic [7:0] STRING_RESET   = 8'h00;
  localparam logic [7:0] SERIAL_DEFAULT = 8'h00;
  localparam logic [1:0] IDX_SERIAL     = 2'h1;
  localparam logic [1:0] IDX_PRODUCT    = 2'h2;
  localparam logic [1:0] IDX_MAKER      = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_DONE = 2'b10
  } udss_state_t;
endpackage

/* File: rtl/udss_byte_array.sv */
/*
  Byte array of flip-flops with one write port and one indexed read port.
  Assumes write strobe and address come from the same clock domain.
*/
`timescale 1ns/10ps
module udss_byte_array #(
  parameter int         DEPTH = 32,
  parameter logic [7:0] INIT  = 8'h00
) (
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrIdx,
  input  wire logic [7:0]               wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdIdx,
  output logic      [7:0]               rdData
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } udss_arr_t;

  udss_arr_t arr_q;
  udss_arr_t arr_d;

  always_comb begin
    arr_d = arr_q;
    if (wrEn) begin
      arr_d.mem[wrIdx] = wrData;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      arr_q <= {DEPTH{INIT}};
    end else begin
      arr_q <= arr_d;
    end
  end

  assign rdData = arr_q.mem[rdIdx];
endmodule

/* File: verif/udss_checker.sv */
/* Port checker of the string store.
   Assumes it is bound to udss_string_store. */
`timescale 1ns/10ps
module udss_checker (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [6:0] makerStringLength,
  input wire logic [6:0] productStringLength,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic       regAck,
  input wire logic       descReq,
  input wire logic [1:0] descIndex,
  input wire logic       descValid,
  input wire logic       descLast,
  input wire logic       descAbsent
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_ack_follows: assert property ((regWrite | regRead) |=> regAck)
    else $error("strobe not acknowledged");
  a_ack_only_after: assert property (!(regWrite | regRead) |=> !regAck)
    else $error("ack without strobe");
  a_maker_absent: assert property ($rose(descReq) && descIndex == 2'h3
    && makerStringLength == 7'h00 |=> descAbsent && !descValid) else $error("maker not absent");
  a_maker_start: assert property ($rose(descReq) && descIndex == 2'h3
    && makerStringLength != 7'h00 |-> ##2 descValid) else $error("maker bytes late");
  a_prod_absent: assert property ($rose(descReq) && descIndex == 2'h2
    && productStringLength == 7'h00 |=> descAbsent) else $error("product not absent");
  a_prod_start: assert property ($rose(descReq) && descIndex == 2'h2
    && productStringLength != 7'h00 |-> ##2 descValid) else $error("product bytes late");
  a_prod_single: assert property ($rose(descReq) && descIndex == 2'h2
    && productStringLength == 7'h01 |-> ##2 descValid && descLast) else $error("length one");
  a_serial_burst: assert property ($rose(descReq) && descIndex == 2'h1
    |-> ##2 descValid [*8]) else $error("serial burst broken");
  a_last_valid: assert property (descLast |-> descValid)
    else $error("last without byte");
endmodule
bind udss_string_store udss_checker u_chk (.mclk, .reset_n, .makerStringLength,
  .productStringLength, .regWrite, .regRead, .regAck, .descReq, .descIndex, .descValid,
  .descLast, .descAbsent);

/* File: verif/udss_host_model.sv */
/* Host model asking the store for string descriptors.
   Assumes falling edge driving and registered answers. */
`timescale 1ns/10ps
module udss_host_model (
  input  wire logic       mclk,
  input  wire logic       descLast,
  input  wire logic       descAbsent,
  output logic            descReq,
  output logic      [1:0] descIndex
);
  initial {descReq, descIndex} = 3'h0;
  task automatic fetch(input logic [1:0] idx);
    int t;
    t = 0;
    @(negedge mclk) {descReq, descIndex} = {1'b1, idx};
    do begin
      @(posedge mclk);
      #1;
    end while (!(descLast | descAbsent) && ++t < 200);
    // Released index line shows the inverse, not the old value
    @(negedge mclk) {descReq, descIndex} = {1'b0, ~idx};
    repeat (2 + $urandom_range(3)) @(negedge mclk);
  endtask
endmodule

/* File: verif/tb_usb_string_descriptor_store.sv */
/* Self-checking bench of the string store.
   Assumes udss_host_model as the descriptor requester. */
`timescale 1ns/10ps
module tb_usb_string_descriptor_store;
  import udss_pkg::*;
  logic       mclk = 1'b0, reset_n = 1'b0, customSerialSelect = 1'b0, rdPend = 1'b0;
  logic       regWrite = 1'b0, regRead = 1'b0, regAck, descReq, descValid, descLast, descAbsent;
  logic [6:0] makerStringLength = 7'h00, productStringLength = 7'h00, len;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, descByte;
  logic [1:0] descIndex;
  logic [7:0] mem [256];
  logic [9:0] expQ [$];
  int         n_fail = 0, samples_checked = 0, cyc = 0;
  always #50 mclk = ~mclk;
  udss_string_store u_dut (.mclk, .reset_n, .customSerialSelect, .makerStringLength,
    .productStringLength, .regWrite, .regRead, .regAddr, .regWrData, .regRdData, .regAck,
    .descReq, .descIndex, .descValid, .descByte, .descLast, .descAbsent);
  udss_host_model u_host (.mclk, .descLast, .descAbsent, .descReq, .descIndex);
  task automatic final_report();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge mclk) {regWrite, regAddr, regWrData} = {1'b1, a, d};
    @(negedge mclk) regWrite = 1'b0;
    if (a inside {[MAKER_BASE:PRODUCT_LAST]} || (a inside {[SERIAL_BASE:SERIAL_LAST]}
        && customSerialSelect)) mem[a] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk) {regRead, regAddr} = {1'b1, a};
    expQ.push_back({2'b00, a inside {[SERIAL_BASE:PRODUCT_LAST]} ? mem[a] : 8'h00});
    @(negedge mclk) regRead = 1'b0;
  endtask
  task automatic ask(input logic [1:0] i, input logic [6:0] n);
    int base;
    base = i == IDX_SERIAL ? int'(SERIAL_BASE) : i == IDX_MAKER ? int'(MAKER_BASE)
      : int'(PRODUCT_BASE);
    if (i == IDX_SERIAL) n = 7'(SERIAL_DEPTH);
    if (n == 7'h00) expQ.push_back(10'h100);
    for (int k = 0; k < n && k < STRING_DEPTH; k++)
      expQ.push_back({k + 1 == n || k == STRING_DEPTH - 1, 1'b0, mem[base + k]});
    u_host.fetch(i);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rdPend <= regRead;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end else if (descValid | descAbsent | (regAck & rdPend)) begin
      samples_checked++;
      if (expQ.size() == 0 || expQ.pop_front() !== {descLast, descAbsent,
          descAbsent ? 8'h00 : (regAck & rdPend) ? regRdData : descByte}) begin
        n_fail++;
        $display("mismatch at %0t: output differs from note", $time);
      end
    end
  end
  initial begin
    void'($urandom(87));
    for (int a = 0; a < 256; a++) mem[a] = 8'h00;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    rd(MAKER_BASE);
    rd(PRODUCT_LAST);
    customSerialSelect = 1'b1;
    for (int a = 8'h30; a <= 8'hCF; a++) begin
      // Maker and product text goes in as UTF-16LE: odd bytes are zero
      wr(8'(a), a >= 8'h50 && a[0] ? 8'h00 : 8'($urandom_range(8'h7E, 8'h20)));
    end
    customSerialSelect = 1'b0;
    wr(SERIAL_BASE, ~mem[SERIAL_BASE]);
    rd(SERIAL_BASE);
    rd(8'hD0);
    rd(8'h2F);
    ask(IDX_SERIAL, 7'h00);
    ask(2'h0, 7'h00);
    for (int j = 0; j < 7; j++) begin
      len = j < 5 ? 7'(j == 4 ? 100 : j * j * 4) : j == 5 ? 7'h01 : 7'($urandom_range(63, 1));
      makerStringLength = len;
      productStringLength = len;
      ask(IDX_MAKER, len);
      ask(IDX_PRODUCT, len);
    end
    repeat (5) @(negedge mclk);
    if (expQ.size() != 0) begin
      n_fail++;
      $display("mismatch at %0t: results missing", $time);
    end
    final_report();
  end
endmodule
